// file: verilog/driver_channel_config_regs.sv
/*
  configuration and test register bank of one laser driver channel:
  shadow registers written by the host, a mode-controlled latch applying
  them to the analog side, fault simulation, alarm pin and sticky flags.
  assumes the serial port decoder gives one-cycle read and write strobes
  with address and data valid in the same cycle, synchronous to clock.
*/
`default_nettype none

module driver_channel_config_regs (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata_r,
  output var  logic       reg_rvalid_r,
  input  wire logic       overtemp_event,
  input  wire logic       overcurrent_event,
  input  wire logic       osc_timeout_event,
  input  wire logic       channel_enable_state,
  output var  logic       reference_swap_r,
  output var  logic       diode_polarity_r,
  output var  logic       negative_ref_range_r,
  output var  logic [5:0] supply_ctrl_current_r,
  output var  logic [1:0] shunt_gain_r,
  output var  logic [5:0] shunt_gain_factor_r,
  output var  logic       converter_divider_enable_r,
  output var  logic       reference_dac_linear_r,
  output var  logic       overtemp_fault_r,
  output var  logic       overcurrent_fault_r,
  output var  logic       osc_fault_r,
  output var  logic       channel_shutdown_r,
  output var  logic       memory_error_r,
  output var  logic       overcurrent_flag,
  output var  logic       osc_failure_flag,
  output var  logic       alarm_pin_o,
  output var  logic       alarm_pin_oe,
  output var  logic       aux_analog_pin_o,
  output var  logic       aux_analog_pin_oe
);

  // ----------------------------------------------------------------------
  // shadow registers written by the host
  // ----------------------------------------------------------------------
  logic       ref_swap_r;
  logic       diode_pol_r;
  logic       neg_range_r;
  logic [5:0] current_r;
  logic [1:0] gain_r;
  logic       osc_mask_r;
  logic       mon_mask_r;
  logic       div_enable_r;
  logic       dac_linear_r;
  logic       sim_ot_r;
  logic       sim_oc_r;
  logic       sim_osc_r;
  logic [1:0] mode_r;
  logic       aux_out_r;

  // applied copies of the masks, simulation bits and aux pin state
  logic       osc_mask_app_r, mon_mask_app_r, sim_ot_app_r, sim_oc_app_r;
  logic       sim_osc_app_r, aux_out_app_r, alarm_r;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic wr_polarity, wr_supply, wr_mask_sim, wr_mode;
  logic rd_status, latch_open, mode_illegal;

  assign wr_polarity  = reg_wr && (reg_addr == driver_cfg_pkg::polarity_off);
  assign wr_supply    = reg_wr && (reg_addr == driver_cfg_pkg::supply_off);
  assign wr_mask_sim  = reg_wr && (reg_addr == driver_cfg_pkg::mask_sim_off);
  assign wr_mode      = reg_wr && (reg_addr == driver_cfg_pkg::mode_off);
  assign rd_status    = reg_rd && (reg_addr == driver_cfg_pkg::status_off);
  // operation mode opens the latch, configuration mode closes it
  assign latch_open   = (mode_r == driver_cfg_pkg::mode_operation);
  // only the two defined codes are legal
  assign mode_illegal = (mode_r != driver_cfg_pkg::mode_operation) &&
                        (mode_r != driver_cfg_pkg::mode_config);

  // ----------------------------------------------------------------------
  // shadow register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_swap_r  <= driver_cfg_pkg::ref_swap_rst;
      diode_pol_r <= driver_cfg_pkg::diode_pol_rst;
      neg_range_r <= driver_cfg_pkg::neg_range_rst;
    end else if (wr_polarity) begin
      ref_swap_r  <= reg_wdata[driver_cfg_pkg::ref_swap_bit];
      diode_pol_r <= reg_wdata[driver_cfg_pkg::diode_pol_bit];
      neg_range_r <= reg_wdata[driver_cfg_pkg::neg_range_bit];
    end
  end

  // supply current and shunt gain share one byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      current_r <= driver_cfg_pkg::current_rst;
      gain_r    <= driver_cfg_pkg::gain_rst;
    end else if (wr_supply) begin
      current_r <= reg_wdata[driver_cfg_pkg::current_lsb +: 6];
      gain_r    <= reg_wdata[driver_cfg_pkg::gain_lsb +: 2];
    end
  end

  // masks, divider, dac characteristic and fault simulation
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_mask_r   <= driver_cfg_pkg::osc_mask_rst;
      mon_mask_r   <= driver_cfg_pkg::mon_mask_rst;
      div_enable_r <= driver_cfg_pkg::div_enable_rst;
      dac_linear_r <= driver_cfg_pkg::dac_linear_rst;
      sim_ot_r     <= driver_cfg_pkg::sim_ot_rst;
      sim_oc_r     <= driver_cfg_pkg::sim_oc_rst;
      sim_osc_r    <= driver_cfg_pkg::sim_osc_rst;
    end else if (wr_mask_sim) begin
      osc_mask_r   <= reg_wdata[driver_cfg_pkg::osc_mask_bit];
      mon_mask_r   <= reg_wdata[driver_cfg_pkg::mon_mask_bit];
      div_enable_r <= reg_wdata[driver_cfg_pkg::div_enable_bit];
      dac_linear_r <= reg_wdata[driver_cfg_pkg::dac_linear_bit];
      sim_ot_r     <= reg_wdata[driver_cfg_pkg::sim_ot_bit];
      sim_oc_r     <= reg_wdata[driver_cfg_pkg::sim_oc_bit];
      sim_osc_r    <= reg_wdata[driver_cfg_pkg::sim_osc_bit];
    end
  end

  // mode field is always writable so the host can leave configuration mode
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_r    <= driver_cfg_pkg::mode_rst;
      aux_out_r <= driver_cfg_pkg::aux_out_rst;
    end else if (wr_mode) begin
      mode_r    <= reg_wdata[driver_cfg_pkg::mode_lsb +: 2];
      aux_out_r <= reg_wdata[driver_cfg_pkg::aux_out_bit];
    end
  end

  // ----------------------------------------------------------------------
  // configuration latch, follows the shadows only in operation mode
  // ----------------------------------------------------------------------
  logic [5:0] gain_factor_nxt;

  // gain code to amplification factor
  assign gain_factor_nxt = (gain_r == 2'h0) ? driver_cfg_pkg::gain_x2 :
                           (gain_r == 2'h1) ? driver_cfg_pkg::gain_x5 :
                           (gain_r == 2'h2) ? driver_cfg_pkg::gain_x10 :
                                              driver_cfg_pkg::gain_x50;

  // analog settings, held while closed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reference_swap_r      <= driver_cfg_pkg::ref_swap_rst;
      diode_polarity_r      <= driver_cfg_pkg::diode_pol_rst;
      negative_ref_range_r  <= driver_cfg_pkg::neg_range_rst;
      supply_ctrl_current_r <= driver_cfg_pkg::current_rst;
    end else if (latch_open) begin
      reference_swap_r      <= ref_swap_r;
      diode_polarity_r      <= diode_pol_r;
      negative_ref_range_r  <= neg_range_r;
      supply_ctrl_current_r <= current_r;
    end
  end

  // gain, divider and dac characteristic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shunt_gain_r               <= driver_cfg_pkg::gain_rst;
      shunt_gain_factor_r        <= driver_cfg_pkg::gain_x2;
      converter_divider_enable_r <= driver_cfg_pkg::div_enable_rst;
      reference_dac_linear_r     <= driver_cfg_pkg::dac_linear_rst;
    end else if (latch_open) begin
      shunt_gain_r               <= gain_r;
      shunt_gain_factor_r        <= gain_factor_nxt;
      converter_divider_enable_r <= div_enable_r;
      reference_dac_linear_r     <= dac_linear_r;
    end
  end

  // masks, simulation and aux pin state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_mask_app_r <= driver_cfg_pkg::osc_mask_rst;
      mon_mask_app_r <= driver_cfg_pkg::mon_mask_rst;
      sim_ot_app_r   <= driver_cfg_pkg::sim_ot_rst;
      sim_oc_app_r   <= driver_cfg_pkg::sim_oc_rst;
      sim_osc_app_r  <= driver_cfg_pkg::sim_osc_rst;
      aux_out_app_r  <= driver_cfg_pkg::aux_out_rst;
    end else if (latch_open) begin
      osc_mask_app_r <= osc_mask_r;
      mon_mask_app_r <= mon_mask_r;
      sim_ot_app_r   <= sim_ot_r;
      sim_oc_app_r   <= sim_oc_r;
      sim_osc_app_r  <= sim_osc_r;
      aux_out_app_r  <= aux_out_r;
    end
  end

  // ----------------------------------------------------------------------
  // fault path, real and simulated faults merge here
  // ----------------------------------------------------------------------
  logic ot_nxt, oc_nxt, osc_nxt, alarm_nxt;

  assign ot_nxt    = overtemp_event | sim_ot_app_r;
  assign oc_nxt    = overcurrent_event | sim_oc_app_r;
  assign osc_nxt   = osc_timeout_event | sim_osc_app_r;
  // alarm pin honours both masks
  assign alarm_nxt = (osc_nxt & ~osc_mask_app_r) |
                     (channel_enable_state & ~mon_mask_app_r);

  // registered faults, shutdown and memory error
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      overtemp_fault_r    <= 1'b0;
      overcurrent_fault_r <= 1'b0;
      osc_fault_r         <= 1'b0;
      channel_shutdown_r  <= 1'b0;
      memory_error_r      <= 1'b0;
      alarm_r             <= 1'b0;
    end else begin
      overtemp_fault_r    <= ot_nxt;
      overcurrent_fault_r <= oc_nxt;
      osc_fault_r         <= osc_nxt;
      channel_shutdown_r  <= ot_nxt | oc_nxt | osc_nxt | mode_illegal;
      memory_error_r      <= mode_illegal;
      alarm_r             <= alarm_nxt;
    end
  end

  // open-drain pins: alarm pulls low when active, aux pulls low on 0
  assign alarm_pin_o       = 1'b0;
  assign alarm_pin_oe      = alarm_r;
  assign aux_analog_pin_o  = 1'b0;
  assign aux_analog_pin_oe = ~aux_out_app_r;

  // ----------------------------------------------------------------------
  // sticky status flags for the overcurrent and oscillator faults, none for overtemperature
  // ----------------------------------------------------------------------
  logic [1:0] flag_set, flag_q;

  assign flag_set = {osc_fault_r, overcurrent_fault_r};

  // flag 0 overcurrent, flag 1 oscillator failure
  generate
    for (genvar i = 0; i < 2; i++) begin : g_flag
      fault_flag u_flag (
        .clock  (clock),
        .rstn   (rstn),
        .fault  (flag_set[i]),
        .clear  (rd_status),
        .flag_r (flag_q[i])
      );
    end
  endgenerate

  assign overcurrent_flag = flag_q[0];
  assign osc_failure_flag = flag_q[1];

  // ----------------------------------------------------------------------
  // read mux, shadow values read back, unmapped reads give zero
  // ----------------------------------------------------------------------
  logic [7:0] rd_status_v, rd_polarity_v, rd_supply_v, rd_mask_sim_v, rd_mode_v, rdata_nxt;

  assign rd_status_v   = {1'b0, flag_q[1], flag_q[0], 5'h00};
  assign rd_polarity_v = {diode_pol_r, ref_swap_r, 1'b0, neg_range_r, 4'h0};
  assign rd_supply_v   = {gain_r, current_r};
  assign rd_mask_sim_v = {sim_osc_r, 1'b0, sim_oc_r, sim_ot_r,
                          dac_linear_r, div_enable_r, mon_mask_r, osc_mask_r};
  assign rd_mode_v     = {5'h00, aux_out_r, mode_r};
  assign rdata_nxt = (reg_addr == driver_cfg_pkg::status_off)   ? rd_status_v   :
                     (reg_addr == driver_cfg_pkg::polarity_off) ? rd_polarity_v :
                     (reg_addr == driver_cfg_pkg::supply_off)   ? rd_supply_v   :
                     (reg_addr == driver_cfg_pkg::mask_sim_off) ? rd_mask_sim_v :
                     (reg_addr == driver_cfg_pkg::mode_off)     ? rd_mode_v     :
                                                                  8'h00;

  // read data held until the next read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r  <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ref_swap_apply_a: assert property (
    latch_open |=> reference_swap_r == $past(ref_swap_r))
    else $error("reference swap not applied");
  diode_pol_apply_a: assert property (
    latch_open |=> diode_polarity_r == $past(diode_pol_r))
    else $error("diode polarity not applied");
  supply_current_a: assert property (
    wr_supply && latch_open ##1 latch_open |=>
    supply_ctrl_current_r == $past(reg_wdata[5:0], 2)) else $error("supply current not applied");
  gain_decode_a: assert property (
    shunt_gain_r == 2'h3 |-> shunt_gain_factor_r == driver_cfg_pkg::gain_x50)
    else $error("gain factor wrong");
  osc_mask_alarm_a: assert property (
    osc_nxt && !osc_mask_app_r |=> alarm_pin_oe) else $error("oscillator error not on alarm pin");
  mon_mask_alarm_a: assert property (
    !osc_nxt && (mon_mask_app_r || !channel_enable_state) |=> !alarm_pin_oe)
    else $error("alarm pin driven while masked");
  sim_overtemp_a: assert property (
    sim_ot_app_r |=> overtemp_fault_r && channel_shutdown_r)
    else $error("simulated overtemperature missed");
  sim_overcurrent_a: assert property (
    sim_oc_app_r |=> ##1 overcurrent_flag) else $error("simulated overcurrent missed");
  sim_osc_error_a: assert property (
    sim_osc_app_r |=> ##1 osc_failure_flag) else $error("simulated oscillator error missed");
  divider_dac_apply_a: assert property (
    latch_open |=> converter_divider_enable_r == $past(div_enable_r) &&
    reference_dac_linear_r == $past(dac_linear_r))
    else $error("divider or dac setting not applied");
  config_hold_a: assert property (
    mode_r == driver_cfg_pkg::mode_config |=> $stable(supply_ctrl_current_r) &&
    $stable(reference_swap_r) && $stable(shunt_gain_r))
    else $error("settings changed in configuration mode");
  illegal_mode_a: assert property (
    mode_illegal |=> memory_error_r && channel_shutdown_r)
    else $error("illegal mode not reported");
  aux_pin_a: assert property (
    latch_open && !aux_out_r |=> aux_analog_pin_oe && !aux_analog_pin_o)
    else $error("aux pin not pulled low");
  status_clear_a: assert property (
    rd_status && !osc_fault_r && !overcurrent_fault_r |=>
    !overcurrent_flag && !osc_failure_flag) else $error("status flags not cleared on read");

  cover_config_cycle_c: cover property (
    mode_r == driver_cfg_pkg::mode_config ##[1:20] latch_open);
  cover_status_read_c: cover property (overcurrent_flag ##1 rd_status);
  cover_alarm_c: cover property (alarm_pin_oe ##1 !alarm_pin_oe);

endmodule

`default_nettype wire

// file: verilog/driver_cfg_pkg.sv
/*
  constants for the driver channel configuration bank: register offsets,
  field positions, reset values, mode codes and gain factors.
  assumes an 8-bit register port driven by the serial interface decoder.
*/
`default_nettype none

package driver_cfg_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] status_off     = 8'h00;
  localparam logic [7:0] polarity_off   = 8'h13;
  localparam logic [7:0] supply_off     = 8'h15;
  localparam logic [7:0] mask_sim_off   = 8'h16;
  localparam logic [7:0] mode_off       = 8'h1C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int neg_range_bit    = 4;
  localparam int ref_swap_bit     = 6;
  localparam int diode_pol_bit    = 7;
  localparam int current_lsb      = 0;
  localparam int gain_lsb         = 6;
  localparam int osc_mask_bit     = 0;
  localparam int mon_mask_bit     = 1;
  localparam int div_enable_bit   = 2;
  localparam int dac_linear_bit   = 3;
  localparam int sim_ot_bit       = 4;
  localparam int sim_oc_bit       = 5;
  localparam int sim_osc_bit      = 7;
  localparam int mode_lsb         = 0;
  localparam int aux_out_bit      = 2;
  localparam int oc_flag_bit      = 5;
  localparam int osc_flag_bit     = 6;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic       ref_swap_rst   = 1'b1;
  localparam logic       diode_pol_rst  = 1'b0;
  localparam logic       neg_range_rst  = 1'b0;
  localparam logic [5:0] current_rst    = 6'h00;
  localparam logic [1:0] gain_rst       = 2'h0;
  localparam logic       osc_mask_rst   = 1'b0;
  localparam logic       mon_mask_rst   = 1'b1;
  localparam logic       div_enable_rst = 1'b1;
  localparam logic       dac_linear_rst = 1'b0;
  localparam logic       sim_ot_rst     = 1'b0;
  localparam logic       sim_oc_rst     = 1'b0;
  localparam logic       sim_osc_rst    = 1'b0;
  localparam logic       aux_out_rst    = 1'b1;

  // ----------------------------------------------------------------------
  // mode codes and gain factors
  // ----------------------------------------------------------------------
  localparam logic [1:0] mode_operation = 2'h1;
  localparam logic [1:0] mode_config    = 2'h2;
  localparam logic [1:0] mode_rst       = 2'h1;
  localparam logic [5:0] gain_x2        = 6'h02;
  localparam logic [5:0] gain_x5        = 6'h05;
  localparam logic [5:0] gain_x10       = 6'h0A;
  localparam logic [5:0] gain_x50       = 6'h32;

endpackage

`default_nettype wire

// file: verilog/fault_flag.sv
/*
  one sticky status flag: set by a fault level, cleared by a status read.
  assumes clear is a one-cycle pulse from the register read decode.
*/
`default_nettype none

module fault_flag (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic fault,
  input  wire logic clear,
  output var  logic flag_r
);

  // ----------------------------------------------------------------------
  // sticky flag, a fault in the clearing cycle keeps it set
  // ----------------------------------------------------------------------
  logic flag_nxt;
  assign flag_nxt = fault | (flag_r & ~clear);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  set_wins_a: assert property (@(posedge clock) disable iff (!rstn)
    fault |=> flag_r) else $error("fault lost at clear");

endmodule

`default_nettype wire

// file: verification/host_port_model.sv
/*
  host side of the register port: one write task and one read task.
  assumes the bank samples its strobes on the rising clock edge.
*/
`default_nettype none

module host_port_model (
  input  wire logic       clock,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_r,
  input  wire logic       reg_rvalid_r
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
  end
  // one-cycle strobe; released lines show inverted leftovers, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read strobe, then wait a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    @(posedge clock) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4 && ok !== 1'b1; i++) begin
      if (reg_rvalid_r === 1'b1) begin
        d = reg_rdata_r;
        ok = 1'b1;
      end else @(posedge clock) #1;
    end
  endtask
endmodule

`default_nettype wire

// file: verification/driver_channel_config_regs_tb.sv
/*
  self-checking bench of the channel configuration bank.
  assumes host_port_model drives the register port.
*/
`default_nettype none

module driver_channel_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rstn, chan_en, wr, rd, rv, sw, dp, nr, de, dl, otf, ocf, osf;
  logic       sd, me, ocg, osg, al_o, al_oe, ax_o, ax_oe, ev_ot, ev_oc, ev_osc;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] cur, fac;
  logic [1:0] gain;
  int         n_errors, n_checks, g;
  host_port_model i_host_port_model (.clock(clock), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rv));
  driver_channel_config_regs i_driver_channel_config_regs (.clock(clock), .rstn(rstn),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata),
    .reg_rvalid_r(rv), .overtemp_event(ev_ot), .overcurrent_event(ev_oc),
    .osc_timeout_event(ev_osc), .channel_enable_state(chan_en), .reference_swap_r(sw),
    .diode_polarity_r(dp), .negative_ref_range_r(nr), .supply_ctrl_current_r(cur),
    .shunt_gain_r(gain), .shunt_gain_factor_r(fac), .converter_divider_enable_r(de),
    .reference_dac_linear_r(dl), .overtemp_fault_r(otf), .overcurrent_fault_r(ocf),
    .osc_fault_r(osf), .channel_shutdown_r(sd), .memory_error_r(me),
    .overcurrent_flag(ocg), .osc_failure_flag(osg), .alarm_pin_o(al_o),
    .alarm_pin_oe(al_oe), .aux_analog_pin_o(ax_o), .aux_analog_pin_oe(ax_oe));
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write, then give the latch, fault and flag stages time to land
  task automatic ws(input logic [7:0] a, input logic [7:0] d);
    i_host_port_model.wr(a, d);
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host_port_model.rd(a, d, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      results();
    end
    chk("readback", exp, d);
  endtask
  // applied setting bits, memory error and shutdown packed for one compare
  function automatic logic [7:0] cfg();
    return {sw, dp, nr, de, dl, ax_oe, me, sd};
  endfunction
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset;
    chk("cfg", 8'h90, cfg());
    chk("supply", 8'h02, {2'h0, fac});
    rc(8'h13, 8'h40);
    rc(8'h16, 8'h06);
    rc(8'h1C, 8'h05);
    rc(8'h7F, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_write;
    ws(8'h13, 8'hD0);
    ws(8'h16, 8'h0C);
    chk("cfg", 8'hF8, cfg());
    for (g = 0; g < 4; g++) begin
      ws(8'h15, {g[1:0], 6'h3F});
      chk("gain", {g[1:0], 6'h3F}, {gain, cur});
      chk("factor", g==0 ? 8'h02 : g==1 ? 8'h05 : g==2 ? 8'h0A : 8'h32, {2'h0, fac});
    end
    ws(8'h15, 8'h00);
    chk("current", 8'h00, {2'h0, cur});
    ws(8'h13, 8'h00);
    ws(8'h16, 8'h06);
    chk("cfg", 8'h10, cfg());
    $display("t_write done");
  endtask
  task automatic t_mode;
    ws(8'h1C, 8'h06);
    ws(8'h13, 8'h80);
    chk("held", 8'h00, {7'h00, dp});
    rc(8'h13, 8'h80);
    ws(8'h1C, 8'h05);
    chk("applied", 8'h01, {7'h00, dp});
    ws(8'h1C, 8'h04);
    chk("illegal", 8'h03, {6'h00, me, sd});
    ws(8'h1C, 8'h07);
    chk("illegal", 8'h03, {6'h00, me, sd});
    ws(8'h1C, 8'h01);
    chk("aux", 8'h02, {6'h00, ax_oe, ax_o});
    ws(8'h1C, 8'h05);
    $display("t_mode done");
  endtask
  task automatic t_fault;
    ws(8'h16, 8'h26);
    chk("oc", 8'h15, {2'h0, otf, ocf, osf, ocg, osg, sd});
    ws(8'h16, 8'h06);
    rc(8'h00, 8'h20);
    rc(8'h00, 8'h00);
    ws(8'h16, 8'h86);
    chk("osc", 8'h0E, {4'h0, osf, osg, al_oe, al_o});
    ws(8'h16, 8'h87);
    chk("masked", 8'h00, {7'h00, al_oe});
    ws(8'h16, 8'h06);
    rc(8'h00, 8'h40);
    rc(8'h00, 8'h00);
    ws(8'h16, 8'h16);
    chk("ot", 8'h03, {6'h00, otf, sd});
    chan_en = 1'b1;
    ws(8'h16, 8'h04);
    chk("monitor", 8'h01, {7'h00, al_oe});
    ws(8'h16, 8'h06);
    chk("monitor", 8'h00, {7'h00, al_oe});
    $display("t_fault done");
  endtask
  // real fault levels take the same path; a read during a fault keeps the flag
  task automatic t_real;
    ev_oc = 1'b1;
    ev_osc = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("real", 8'h3F, {2'h0, ocf, osf, ocg, osg, al_oe, sd});
    rc(8'h00, 8'h60);
    rc(8'h00, 8'h60);
    ev_oc = 1'b0;
    ev_osc = 1'b0;
    ev_ot = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("real", 8'h4D, {1'b0, otf, ocf, osf, ocg, osg, al_oe, sd});
    ev_ot = 1'b0;
    rc(8'h00, 8'h60);
    rc(8'h00, 8'h00);
    $display("t_real done");
  endtask
  // clock, reset and main sequence with a global limit
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    ev_ot = 1'b0;
    ev_oc = 1'b0;
    ev_osc = 1'b0;
    chan_en = 1'b0;
    repeat (16) @(posedge clock);
    #1 rstn = 1'b1;
    t_reset();
    t_write();
    t_mode();
    t_fault();
    t_real();
    results();
  end
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule

`default_nettype wire
